// [src/iprio_top.sv]
`timescale 1ns/100ps
module iprio_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [iprio_pkg::IPRIO_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [iprio_pkg::IPRIO_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output iprio_pkg::iprio_levels_t levels,
  output logic [17:0] source_enabled
);
  import iprio_pkg::*;

  // ************************************************************
  // behaviour notes
  // ************************************************************
  // register port is axi4-lite: up to two writes and one read in flight
  // write address and write data may arrive in either order
  // each half parks in its own holding flop until the other comes
  // a parked half drops its ready, so nothing is ever overwritten
  // the write commits once both halves are parked and b is free
  // the commit edge raises bvalid and loads the addressed fields
  // levels toward the arbiter change on that same commit edge
  // a read answers on the same edge that takes its address
  // read data is the bank value at the accept edge
  // a write committing on that edge is not yet visible to the read
  // only wdata[15:0] and wstrb[1:0] reach the bank
  // wstrb[0] covers the two low fields, wstrb[1] the two high ones
  // the upper halfword of rdata always reads zero
  // bit 3 of every nibble is a gap bit: no flop, reads zero
  // fields in an unimplemented slot have no flop at all
  // an unmapped or unaligned offset answers slverr
  // an unmapped write leaves every field untouched
  // an unmapped read returns zero data with slverr
  // awprot and arprot are accepted and not used

  // ************************************************************
  // clock enable and reset
  // ************************************************************
  // clock enable low freezes every flop, the bank included
  // readies drop while frozen, so no request is taken and lost
  // a pending bvalid or rvalid keeps standing while frozen
  // the master must not complete a response while frozen:
  // the slot would stay full and the answer would show twice
  // reset is synchronous and wins over the clock enable
  // reset empties both holding flops and both answer slots
  // reset loads 100 into every implemented field
  // so every source comes out of reset enabled at level four
  // hold reset for at least one edge before the first request

  // ************************************************************
  // level outputs
  // ************************************************************
  // levels is a packed set of eighteen 3-bit levels
  // the level equals the field value, seven highest, one lowest
  // a level of zero means the source is switched off
  // source_enabled carries one bit per source in the same order
  // both come straight from the field flops, no extra delay

  // ************************************************************
  // declarations
  // ************************************************************
  // write channel state
  logic aw_held_q; // write address captured
  logic w_held_q; // write data captured
  logic [IPRIO_AW-1:0] awaddr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  // write response slot
  logic bvalid_q;
  logic [1:0] bresp_q;
  // read answer slot
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  // commit strobe and bank request
  logic do_write; // both halves present, response free
  iprio_wr_t wr;
  // bank outputs, one entry per register
  logic [15:0] reg_val [IPRIO_NREG];
  logic [3:0] reg_en [IPRIO_NREG];
  // decoded indices and hits
  logic [2:0] wr_idx;
  logic wr_hit;
  logic [2:0] rd_idx;
  logic rd_hit;

  // ************************************************************
  // address decode
  // ************************************************************
  // map a byte address to a register index
  // offsets not in the table miss
  // idx stays 0 on a miss, so the bank index is always legal
  function automatic logic decode(input logic [IPRIO_AW-1:0] a, output logic [2:0] idx);
    logic hit;
    hit = 1'b1;
    idx = 3'h0;
    unique case (a)
      IPRIO_OFF_TIMER4_COMPARE34: idx = 3'h0;
      IPRIO_OFF_UART2_EXT2_TIMER5: idx = 3'h1;
      IPRIO_OFF_SPI2: idx = 3'h2;
      IPRIO_OFF_CAPTURE345: idx = 3'h3;
      IPRIO_OFF_COMPARE567_CAPTURE6: idx = 3'h4;
      IPRIO_OFF_PARPORT_COMPARE8: idx = 3'h5;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // write side decodes the parked address
  // read side decodes the live address, taken at the same edge
  always_comb begin
    wr_hit = decode(awaddr_q, wr_idx);
    rd_hit = decode(s_axi_araddr, rd_idx);
  end

  // ************************************************************
  // write channel
  // ************************************************************
  // readies drop while a half is parked or the clock is frozen
  assign s_axi_awready = ce && !aw_held_q;
  assign s_axi_wready = ce && !w_held_q;
  // commit only once both halves are in and the answer slot is free
  assign do_write = ce && aw_held_q && w_held_q && !bvalid_q;

  // held until the write commits, then freed
  // capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // upper halfword and upper strobes are dropped here
  // capture write data, low halfword only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[15:0];
        wstrb_q <= s_axi_wstrb[1:0];
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // bvalid stands until bready, slverr on a miss
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= IPRIO_RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? IPRIO_RESP_OKAY : IPRIO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // a miss never raises the bank write enable
  // write request toward the register bank
  always_comb begin
    wr.en = do_write && wr_hit;
    wr.idx = wr_idx;
    wr.data = wdata_q;
    wr.strb = wstrb_q;
  end

  // ************************************************************
  // register bank
  // ************************************************************
  // implemented-bit mask per register, in index order
  // a zero nibble in a mask means no storage in that slot
  localparam logic [15:0] MASKS [IPRIO_NREG] = '{
    IPRIO_MASK_TIMER4_COMPARE34,
    IPRIO_MASK_UART2_EXT2_TIMER5,
    IPRIO_MASK_SPI2,
    IPRIO_MASK_CAPTURE345,
    IPRIO_MASK_COMPARE567_CAPTURE6,
    IPRIO_MASK_PARPORT_COMPARE8
  };

  // one register instance per index
  // the write enable reaches only the addressed register
  for (genvar r = 0; r < IPRIO_NREG; r++) begin : g_reg
    iprio_reg #(
      .MASK(MASKS[r])
    ) u_reg (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr_en(wr.en && (wr.idx == 3'(r))),
      .wr_data(wr.data),
      .wr_strb(wr.strb),
      .value(reg_val[r]),
      .enabled(reg_en[r])
    );
  end

  // ************************************************************
  // read channel
  // ************************************************************
  // address taken only while no answer is pending and not frozen
  assign s_axi_arready = ce && !rvalid_q;

  // bank value captured at the accept edge
  // one-cycle read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= IPRIO_RESP_OKAY;
      rdata_q <= '0;
    end else if (ce) begin
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_hit ? IPRIO_RESP_OKAY : IPRIO_RESP_SLVERR;
        rdata_q <= rd_hit ? {16'h0000, reg_val[rd_idx]} : 32'h0000_0000;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ************************************************************
  // level outputs toward the arbiter
  // ************************************************************
  // field placement per register
  // gap bits are never routed here
  assign levels.timer_four_prio = reg_val[0][14:12];
  assign levels.compare_four_prio = reg_val[0][10:8];
  assign levels.compare_three_prio = reg_val[0][6:4];
  assign levels.serial_two_tx_prio = reg_val[1][14:12];
  assign levels.serial_two_rx_prio = reg_val[1][10:8];
  assign levels.ext_irq_two_prio = reg_val[1][6:4];
  assign levels.timer_five_prio = reg_val[1][2:0];
  assign levels.sync_serial_two_event_prio = reg_val[2][6:4];
  assign levels.sync_serial_two_fault_prio = reg_val[2][2:0];
  assign levels.capture_five_prio = reg_val[3][14:12];
  assign levels.capture_four_prio = reg_val[3][10:8];
  assign levels.capture_three_prio = reg_val[3][6:4];
  assign levels.compare_seven_prio = reg_val[4][14:12];
  assign levels.compare_six_prio = reg_val[4][10:8];
  assign levels.compare_five_prio = reg_val[4][6:4];
  assign levels.capture_six_prio = reg_val[4][2:0];
  assign levels.parallel_port_prio = reg_val[5][6:4];
  assign levels.compare_eight_prio = reg_val[5][2:0];

  // a zero level disables its source
  // the arbiter ignores a disabled source outright
  // per-source enable, same order as levels, msb first
  assign source_enabled = {
    reg_en[0][3], reg_en[0][2], reg_en[0][1],
    reg_en[1][3], reg_en[1][2], reg_en[1][1], reg_en[1][0],
    reg_en[2][1], reg_en[2][0],
    reg_en[3][3], reg_en[3][2], reg_en[3][1],
    reg_en[4][3], reg_en[4][2], reg_en[4][1], reg_en[4][0],
    reg_en[5][1], reg_en[5][0]
  };

endmodule

// [src/iprio_pkg.sv]
package iprio_pkg;

  // ************************************************************
  // register map, byte addresses on the axi4-lite port
  // ************************************************************
  localparam int unsigned IPRIO_NREG = 6;
  localparam int unsigned IPRIO_AW = 5;
  localparam logic [4:0] IPRIO_OFF_TIMER4_COMPARE34 = 5'h00;
  localparam logic [4:0] IPRIO_OFF_UART2_EXT2_TIMER5 = 5'h04;
  localparam logic [4:0] IPRIO_OFF_SPI2 = 5'h08;
  localparam logic [4:0] IPRIO_OFF_CAPTURE345 = 5'h0c;
  localparam logic [4:0] IPRIO_OFF_COMPARE567_CAPTURE6 = 5'h10;
  localparam logic [4:0] IPRIO_OFF_PARPORT_COMPARE8 = 5'h14;

  // ************************************************************
  // field layout: four 3-bit field slots per 16-bit register
  // ************************************************************
  localparam int unsigned IPRIO_FW = 3;
  localparam int unsigned IPRIO_FPOS0 = 0;
  localparam int unsigned IPRIO_FPOS1 = 4;
  localparam int unsigned IPRIO_FPOS2 = 8;
  localparam int unsigned IPRIO_FPOS3 = 12;
  localparam logic [2:0] IPRIO_FIELD_RESET = 3'h4;
  localparam logic [2:0] IPRIO_LEVEL_OFF = 3'h0;

  // implemented-bit masks per register
  localparam logic [15:0] IPRIO_MASK_TIMER4_COMPARE34 = 16'h7770;
  localparam logic [15:0] IPRIO_MASK_UART2_EXT2_TIMER5 = 16'h7777;
  localparam logic [15:0] IPRIO_MASK_SPI2 = 16'h0077;
  localparam logic [15:0] IPRIO_MASK_CAPTURE345 = 16'h7770;
  localparam logic [15:0] IPRIO_MASK_COMPARE567_CAPTURE6 = 16'h7777;
  localparam logic [15:0] IPRIO_MASK_PARPORT_COMPARE8 = 16'h0077;
  // power-on value: 100 in every implemented field
  localparam logic [15:0] IPRIO_RESET_ALL = 16'h4444;

  // ************************************************************
  // axi responses
  // ************************************************************
  localparam logic [1:0] IPRIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPRIO_RESP_SLVERR = 2'h2;

  // ************************************************************
  // carriers
  // ************************************************************
  // one register write request
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [15:0] data;
    logic [1:0] strb;
  } iprio_wr_t;

  // priority levels of the eighteen sources
  typedef struct packed {
    logic [2:0] timer_four_prio;
    logic [2:0] compare_four_prio;
    logic [2:0] compare_three_prio;
    logic [2:0] serial_two_tx_prio;
    logic [2:0] serial_two_rx_prio;
    logic [2:0] ext_irq_two_prio;
    logic [2:0] timer_five_prio;
    logic [2:0] sync_serial_two_event_prio;
    logic [2:0] sync_serial_two_fault_prio;
    logic [2:0] capture_five_prio;
    logic [2:0] capture_four_prio;
    logic [2:0] capture_three_prio;
    logic [2:0] compare_seven_prio;
    logic [2:0] compare_six_prio;
    logic [2:0] compare_five_prio;
    logic [2:0] capture_six_prio;
    logic [2:0] parallel_port_prio;
    logic [2:0] compare_eight_prio;
  } iprio_levels_t;

endpackage

// [src/iprio_field.sv]
`timescale 1ns/100ps
// one 3-bit priority field with write strobe
module iprio_field (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_data,
  output logic [2:0] level,
  output logic enabled
);
  import iprio_pkg::*;

  logic [2:0] level_q;

  // ************************************************************
  // field storage
  // ************************************************************
  // reset to 100, then last written value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= IPRIO_FIELD_RESET;
    end else if (ce && wr_en) begin
      level_q <= wr_data;
    end
  end

  // field value is the level itself, 111 top, 001 lowest
  assign level = level_q;
  // zero disables the source
  assign enabled = (level_q != IPRIO_LEVEL_OFF);

endmodule

// [src/iprio_reg.sv]
`timescale 1ns/100ps
// one 16-bit priority register of four field slots
module iprio_reg #(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_strb,
  output logic [15:0] value,
  output logic [3:0] enabled
);
  import iprio_pkg::*;

  logic [15:0] raw;

  // ************************************************************
  // field slots
  // ************************************************************
  // only masked slots hold storage
  for (genvar i = 0; i < 4; i++) begin : g_slot
    if (MASK[i*4]) begin : g_impl
      logic [2:0] lvl;
      logic en;
      iprio_field u_field (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .wr_en(wr_en && wr_strb[i/2]),
        .wr_data(wr_data[i*4 +: 3]),
        .level(lvl),
        .enabled(en)
      );
      assign raw[i*4 +: 4] = {1'b0, lvl};
      assign enabled[i] = en;
    end else begin : g_none
      // unimplemented slot reads zero
      assign raw[i*4 +: 4] = 4'h0;
      assign enabled[i] = 1'b0;
    end
  end

  // gap bits forced to zero
  assign value = raw & MASK;

endmodule

// [verification/iprio_chk_assertions.sv]
`timescale 1ns/100ps
// ****
// port checks
// ****
module iprio_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire iprio_pkg::iprio_levels_t levels,
  input wire logic [17:0] source_enabled
);
  import iprio_pkg::*;
  logic [17:0] nonzero; // level not zero, per source
  logic wr_go; // both write halves taken
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  // per-source nonzero reduction
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      nonzero[i] = |levels[3*i+:3];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (wr_go && !s_axi_bvalid && s_axi_awaddr[1:0] == 2'h0 |-> ##2 s_axi_bvalid &&
    s_axi_bresp == (($past(s_axi_awaddr, 2) <= 5'h14) ? IPRIO_RESP_OKAY : IPRIO_RESP_SLVERR))
    else $error("bad write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rvalid &&
    (($past(s_axi_araddr) <= 5'h14) ? s_axi_rresp == IPRIO_RESP_OKAY : s_axi_rdata == 32'h0))
    else $error("bad read answer");
  a_unused_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hffff_8888) == 32'h0)
    else $error("unused bits set");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_off_flag: assert property (source_enabled == nonzero)
    else $error("enable flag wrong");
  a_reset_fields: assert property (!$past(aresetn) |-> levels == {18{IPRIO_FIELD_RESET}})
    else $error("reset level wrong");
  a_field_lands: assert property (wr_go && s_axi_awaddr == 5'h04 && s_axi_wstrb[1:0] == 2'h3 |-> ##2
    levels.serial_two_tx_prio == $past(s_axi_wdata[14:12], 2) && levels.timer_five_prio == $past(s_axi_wdata[2:0], 2))
    else $error("field not written");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == IPRIO_RESP_SLVERR);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (source_enabled == 18'h0);
  cover property (!ce && s_axi_awvalid);
endmodule

// [verification/iprio_top_tb_top.sv]
`timescale 1ns/100ps
// ****
// register bank bench
// ****
module iprio_top_tb_top;
  import iprio_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  iprio_levels_t levels;
  logic [17:0] source_enabled;
  int fail_count = 0, checks = 0;
  logic [4:0] adr [6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14}; // register addresses
  logic [15:0] msk [6] = '{16'h7770, 16'h7777, 16'h0077, 16'h7770, 16'h7777, 16'h0077}; // live bits
  logic [15:0] pat [6] = '{16'h9abf, 16'hcdef, 16'hff12, 16'h3456, 16'h7016, 16'h0025}; // field mix
  always #5 aclk = ~aclk;
  iprio_top i_dut (.*);
  // comparisons
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_l(input logic [53:0] got, input logic [53:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // write; bready raised after lag cycles
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er, input int lag);
    logic aw_go, w_go, b_go;
    logic [1:0] resp;
    int n;
    n = 0;
    b_go = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!b_go) begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      b_go = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (b_go) s_axi_bready <= 1'b0;
      else if (n >= lag) s_axi_bready <= 1'b1;
    end
    chk_r(resp, er);
  endtask
  // read; rready raised after lag cycles
  task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er, input int lag);
    logic ar_go, r_go;
    logic [31:0] d;
    logic [1:0] resp;
    int n;
    n = 0;
    r_go = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    while (!r_go) begin
      @(negedge aclk);
      ar_go = s_axi_arvalid && s_axi_arready;
      r_go = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (r_go) s_axi_rready <= 1'b0;
      else if (n >= lag) s_axi_rready <= 1'b1;
    end
    chk_w(d, ed);
    chk_r(resp, er);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    give_verdict;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int r = 0; r < 6; r++) begin
      rd(adr[r], {16'h0, 16'h4444 & msk[r]}, IPRIO_RESP_OKAY, 0);
    end
    for (int r = 0; r < 6; r++) begin
      wr(adr[r], 32'hffff_ffff, 4'hf, IPRIO_RESP_OKAY, 0);
      rd(adr[r], {16'h0, msk[r]}, IPRIO_RESP_OKAY, r);
    end
    chk_l(levels, {18{3'h7}});
    for (int r = 0; r < 6; r++) begin
      wr(adr[r], 32'h0, 4'hf, IPRIO_RESP_OKAY, r);
    end
    chk_l(levels, 54'h0);
    chk_w({14'h0, source_enabled}, 32'h0);
    for (int r = 0; r < 6; r++) begin
      wr(adr[r], {16'hffff, pat[r]}, 4'hf, IPRIO_RESP_OKAY, 0);
      rd(adr[r], {16'h0, pat[r] & msk[r]}, IPRIO_RESP_OKAY, 0);
    end
    chk_l(levels, {3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2,
      3'h3, 3'h4, 3'h5, 3'h7, 3'h0, 3'h1, 3'h6, 3'h2, 3'h5});
    chk_w({14'h0, source_enabled}, 32'h0003_ffef);
    wr(adr[1], 32'h0, 4'h1, IPRIO_RESP_OKAY, 0);
    rd(adr[1], 32'h0000_4500, IPRIO_RESP_OKAY, 0);
    wr(5'h18, 32'hffff_ffff, 4'hf, IPRIO_RESP_SLVERR, 2);
    rd(5'h1c, 32'h0, IPRIO_RESP_SLVERR, 2);
    ce <= 1'b0;
    fork
      wr(adr[2], 32'h0000_0031, 4'hf, IPRIO_RESP_OKAY, 0);
      begin
        repeat (4) @(posedge aclk);
        chk_w({31'h0, s_axi_awready}, 32'h0);
        chk_w({29'h0, levels.sync_serial_two_event_prio}, 32'h1);
        ce <= 1'b1;
      end
    join
    rd(adr[2], 32'h0000_0031, IPRIO_RESP_OKAY, 0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(adr[4], 32'h0000_4444, IPRIO_RESP_OKAY, 0);
    chk_l(levels, {18{3'h4}});
    give_verdict;
  end
endmodule
bind iprio_top iprio_chk i_chk (.*);
